// ===== lcdc_params.svh
// constants for the lcd command decoder
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH
`define LCDC_CONT_BIT     7
`define LCDC_MODE_STATIC  2'h1
`define LCDC_MODE_MUX2    2'h2
`define LCDC_MODE_MUX3    2'h3
`define LCDC_MODE_MUX4    2'h0
`define LCDC_RST_MODE     2'h0
`define LCDC_RST_PTR      5'h00
`define LCDC_RST_SUB      3'h0
`define LCDC_PTR_LAST     5'h1F
`endif

// ===== lcdc_pkg.sv
// types for the lcd command decoder
package lcdc_pkg;
  typedef enum logic [1:0] {
    LCDC_IDLE = 2'h0,
    LCDC_CMD  = 2'h1,
    LCDC_DATA = 2'h3
  } lcdc_state_t;

  typedef struct packed {
    logic       display_en;
    logic       bias_half;
    logic [1:0] drive_mode;
    logic       in_bank;
    logic       out_bank;
    logic       blink_alt_bank;
    logic [1:0] blink_rate_sel;
  } lcdc_status_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [3:0] mask;
    logic [3:0] data;
  } lcdc_ram_wr_t;
endpackage

// ===== lcdc_decoder.sv
// lcd driver command decoder and display controller state
`include "lcdc_params.svh"

module lcdc_decoder (
  input  wire logic              clk_i,       // 40 MHz clock
  input  wire logic              rst_i,       // sync reset, active high
  input  wire logic              start_i,     // addressed transfer begins
  input  wire logic              stop_i,      // transfer ends
  input  wire logic              byte_vld_i,  // complete byte received
  input  wire logic [7:0]        byte_i,      // received byte
  input  wire logic [2:0]        hw_sub_i,    // hardware subaddress pins
  output logic                   ack_o,       // acknowledge this byte
  output lcdc_pkg::lcdc_status_t status_o,    // display status state
  output logic                   blink_alt_o, // effective alternate blink
  output logic [4:0]             ptr_o,       // ram address pointer
  output logic [2:0]             sub_o,       // subaddress counter
  output lcdc_pkg::lcdc_ram_wr_t ram_wr_o     // ram write strobe and data
);
  import lcdc_pkg::*;

  // ==========================================================
  // helpers

  // drive modes that have two ram banks (static and 1:2)
  function automatic logic mode_banks(input logic [1:0] mode);
    mode_banks = (mode == `LCDC_MODE_STATIC) ||
                 (mode == `LCDC_MODE_MUX2);
  endfunction

  // status after reset: display off, 1:4 multiplex, bank 0, no blink
  localparam lcdc_status_t STAT_RST = '{
    display_en     : 1'b0,
    bias_half      : 1'b0,
    drive_mode     : `LCDC_RST_MODE,
    in_bank        : 1'b0,
    out_bank       : 1'b0,
    blink_alt_bank : 1'b0,
    blink_rate_sel : 2'h0
  };

  // ==========================================================
  // state and decode signals

  lcdc_state_t  st_r;      // transfer phase
  lcdc_state_t  st_nxt;    // next transfer phase
  lcdc_status_t stat_r;    // display controller status
  lcdc_status_t stat_nxt;  // next status
  logic [4:0]   ptr_r;     // display ram pointer
  logic [4:0]   ptr_nxt;   // next pointer
  logic [2:0]   sub_r;     // subaddress counter
  logic [2:0]   sub_nxt;   // next subaddress
  lcdc_ram_wr_t wr_r;      // registered ram write
  lcdc_ram_wr_t wr_nxt;    // next ram write
  logic         sel;       // counter matches the pins
  logic         cmd_vld;   // command byte taken
  logic         dat_vld;   // display byte taken
  logic         is_ptr;    // pointer load pattern
  logic         is_mode;   // mode-set pattern
  logic         is_sub;    // subaddress select pattern
  logic         is_bank;   // bank-select pattern
  logic         is_blink;  // blink-select pattern
  logic [7:0]   b;         // byte under decode
  logic [1:0]   m;         // current drive mode

  // ==========================================================
  // byte classification

  // short aliases for the decode below
  assign b = byte_i;
  assign m = stat_r.drive_mode;

  // start and stop win over a byte in the same cycle
  assign cmd_vld = byte_vld_i && !start_i && !stop_i &&
                   (st_r == LCDC_CMD);
  assign dat_vld = byte_vld_i && !start_i && !stop_i &&
                   (st_r == LCDC_DATA);

  assign is_ptr   = (b[6:5] == 2'h0);
  assign is_mode  = (b[6:5] == 2'h2);
  assign is_sub   = (b[6:3] == 4'hC);
  assign is_bank  = (b[6:2] == 5'h1E);
  assign is_blink = (b[6:3] == 4'hE);

  assign sel = (sub_r == hw_sub_i);

  // ==========================================================
  // acknowledge

  // commands always, data only when this device is selected
  always_comb begin
    ack_o = 1'b0;
    if (byte_vld_i) begin
      ack_o = (st_r == LCDC_CMD) || (st_r == LCDC_DATA && sel);
    end
  end

  // ==========================================================
  // transfer phase

  // start opens the command phase, stop returns to idle
  always_comb begin
    st_nxt = st_r;
    if (start_i) begin
      st_nxt = LCDC_CMD;
    end else if (stop_i) begin
      st_nxt = LCDC_IDLE;
    end else if (cmd_vld && !b[`LCDC_CONT_BIT]) begin
      st_nxt = LCDC_DATA;
    end
  end

  // phase register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= LCDC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // status state

  // fields a command does not carry keep their value
  always_comb begin
    stat_nxt = stat_r;
    if (cmd_vld && is_mode) begin
      stat_nxt.display_en = b[3];
      stat_nxt.bias_half  = b[2];
      stat_nxt.drive_mode = b[1:0];
    end
    if (cmd_vld && is_bank && mode_banks(m)) begin
      stat_nxt.in_bank  = b[1];
      stat_nxt.out_bank = b[0];
    end
    if (cmd_vld && is_blink) begin
      stat_nxt.blink_alt_bank = b[2];
      stat_nxt.blink_rate_sel = b[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ==========================================================
  // pointer and subaddress counter

  // loads from commands; the pointer advances after every display byte, the subaddress only when the pointer wraps
  always_comb begin
    ptr_nxt = ptr_r;
    sub_nxt = sub_r;
    if (cmd_vld && is_ptr) begin
      ptr_nxt = b[4:0];
    end
    if (cmd_vld && is_sub) begin
      sub_nxt = b[2:0];
    end
    if (dat_vld) begin
      if (ptr_r == `LCDC_PTR_LAST) begin
        ptr_nxt = 5'h00;
        sub_nxt = sub_r + 3'h1;
      end else begin
        ptr_nxt = ptr_r + 5'h01;
      end
    end
  end

  // pointer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= `LCDC_RST_PTR;
      sub_r <= `LCDC_RST_SUB;
    end else begin
      ptr_r <= ptr_nxt;
      sub_r <= sub_nxt;
    end
  end

  // ==========================================================
  // ram write

  // one address per byte, bits taken msb first; the strobe is
  // a single cycle and stays low when another device is selected
  always_comb begin
    wr_nxt = '0;
    if (dat_vld) begin
      wr_nxt.we   = sel;
      wr_nxt.addr = ptr_r;
      unique case (m)
        `LCDC_MODE_STATIC: begin
          wr_nxt.mask = stat_r.in_bank ? 4'h4 : 4'h1;
          wr_nxt.data = {1'b0, b[7], 1'b0, b[7]};
        end
        `LCDC_MODE_MUX2: begin
          wr_nxt.mask = stat_r.in_bank ? 4'hC : 4'h3;
          wr_nxt.data = {b[6], b[7], b[6], b[7]};
        end
        `LCDC_MODE_MUX3: begin
          wr_nxt.mask = 4'h7;
          wr_nxt.data = {1'b0, b[5], b[6], b[7]};
        end
        `LCDC_MODE_MUX4: begin
          wr_nxt.mask = 4'hF;
          wr_nxt.data = {b[4], b[5], b[6], b[7]};
        end
      endcase
    end
  end

  // write strobe register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  // ==========================================================
  // outputs

  // alternate blink only in banked modes
  assign blink_alt_o = stat_r.blink_alt_bank && mode_banks(m);
  // registered state straight to the ports
  assign status_o    = stat_r;
  assign ptr_o       = ptr_r;
  assign sub_o       = sub_r;
  assign ram_wr_o    = wr_r;
endmodule

// ===== lcdc_sva.sv
// assertions for the lcd command decoder
module lcdc_sva import lcdc_pkg::*; (
  input logic         clk_i,       // clk
  input logic         rst_i,       // rst
  input logic         start_i,     // start
  input logic         stop_i,      // stop
  input logic         byte_vld_i,  // strobe
  input logic [7:0]   byte_i,      // byte
  input logic [2:0]   hw_sub_i,    // pins
  input logic         ack_o,       // ack
  input lcdc_status_t status_o,    // status
  input logic         blink_alt_o, // blink
  input logic [4:0]   ptr_o,       // pointer
  input logic [2:0]   sub_o        // counter
);
  // phase 0 idle, 1 command, 2 data
  logic [1:0] ph_r, ph_nxt, bk;
  logic       cb, db, mx;
  assign cb = byte_vld_i && !start_i && !stop_i && ph_r == 2'h1;
  assign db = byte_vld_i && !start_i && !stop_i && ph_r == 2'h2;
  assign mx = status_o.drive_mode[1] == status_o.drive_mode[0];
  assign bk = {status_o.in_bank, status_o.out_bank};
  always_comb begin
    ph_nxt = stop_i ? 2'h0 : ph_r;
    if (cb && !byte_i[7]) ph_nxt = 2'h2;
    if (start_i) ph_nxt = 2'h1;
    if (rst_i) ph_nxt = 2'h0;
  end
  // phase register
  always_ff @(posedge clk_i) ph_r <= ph_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ptr_load: assert property (cb && byte_i[6:5] == 2'h0
    |=> ptr_o == $past(byte_i[4:0])) else $error("ptr");
  a_sub_load: assert property (cb && byte_i[6:3] == 4'hC
    |=> sub_o == $past(byte_i[2:0])) else $error("sub");
  a_bank_sel: assert property (cb && byte_i[6:2] == 5'h1E && !mx
    |=> bk == $past(byte_i[1:0])) else $error("bank");
  a_bank_hold: assert property (cb && byte_i[6:2] == 5'h1E && mx
    |=> $stable(bk)) else $error("hold");
  a_blink_sel: assert property (cb && byte_i[6:3] == 4'hE
    |=> status_o[2:0] == $past(byte_i[2:0])) else $error("blink");
  a_blink_eff: assert property (
    blink_alt_o == (status_o.blink_alt_bank && !mx)) else $error("alt");
  a_byte_ack: assert property (byte_vld_i && ph_r != 2'h0
    |-> ack_o == (cb || sub_o == hw_sub_i)) else $error("ack");
  a_ptr_adv: assert property (db |=> ptr_o == $past(ptr_o) + 5'h01)
    else $error("adv");
  a_sub_wrap: assert property (db && ptr_o == 5'h1F
    |=> sub_o == $past(sub_o) + 3'h1) else $error("wrap");
endmodule
bind lcdc_decoder lcdc_sva u_sva (.*);

// ===== lcdc_master.sv
// bus master model that frames and sends bytes
module lcdc_master (
  input  logic       clk_i,          // clk
  input  logic       ack_i,          // ack
  output logic       start_o = 1'b0, // start
  output logic       stop_o = 1'b0,  // stop
  output logic       vld_o = 1'b0,   // strobe
  output logic [7:0] byte_o = 8'h00  // byte
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic pulse(input logic s);
    @(negedge clk_i);
    start_o = s;
    stop_o = !s;
    @(negedge clk_i);
    start_o = 1'b0;
    stop_o = 1'b0;
  endtask
  // one byte, held through its edge
  task automatic put(input logic [7:0] b, output logic k);
    @(negedge clk_i);
    vld_o = 1'b1;
    byte_o = b;
    @(posedge clk_i);
    k = ack_i;
    @(negedge clk_i);
    vld_o = 1'b0;
    byte_o = ~b;
  endtask
endmodule

// ===== lcdc_decoder_bench.sv
// testbench for the lcd command decoder
module lcdc_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       s, p, v, k, a;
  logic [7:0] b;
  logic [2:0] hs = 3'h5;
  int         miscompares = 0, check_count = 0, cyc = 0;
  lcdc_master u_mst (.clk_i(clk_i), .ack_i(k), .start_o(s), .stop_o(p),
    .vld_o(v), .byte_o(b));
  lcdc_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(s), .stop_i(p),
    .byte_vld_i(v), .byte_i(b), .hw_sub_i(hs), .ack_o(k), .status_o(),
    .blink_alt_o(), .ptr_o(), .sub_o(), .ram_wr_o());
  initial forever #12.5 clk_i = ~clk_i;
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // report and stop
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // 1:4 after reset: bank ignored, blink normal
  task automatic t_mux4;
    u_mst.pulse(1'b1);
    u_mst.put(8'hFB, a);
    u_mst.put(8'hF6, a);
    chk({u_dut.blink_alt_o, u_dut.status_o[6:0]}, 8'h06);
    u_mst.pulse(1'b0);
  endtask
  // static mode, data across a pointer wrap into the next subaddress
  task automatic t_static;
    u_mst.pulse(1'b1);
    u_mst.put(8'hC1, a);
    u_mst.put(8'hFB, a);
    u_mst.put(8'hE5, a);
    u_mst.put(8'h1F, a);
    chk({u_dut.blink_alt_o, u_dut.status_o[6:0]}, 8'hBE);
    chk({u_dut.sub_o, u_dut.ptr_o}, 8'hBF);
    u_mst.put(8'hA0, a);
    chk(8'({u_dut.ram_wr_o[13:8], a}), 8'h7F);
    chk(u_dut.ram_wr_o[7:0] & 8'hF4, 8'h44);
    chk({u_dut.sub_o, u_dut.ptr_o}, 8'hC0);
    u_mst.put(8'h55, a);
    chk(8'({u_dut.ram_wr_o[13], a}), 8'h00);
    u_mst.pulse(1'b0);
    u_mst.put(8'h02, a);
    chk({a, u_dut.sub_o, u_dut.ptr_o[3:0]}, 8'h61);
  endtask
  // 1:2 and 1:3 filling order, banks and blink per mode
  task automatic t_mux23;
    u_mst.pulse(1'b1);
    u_mst.put(8'hC2, a);
    u_mst.put(8'hF8, a);
    u_mst.put(8'hE5, a);
    u_mst.put(8'h03, a);
    chk({u_dut.blink_alt_o, u_dut.status_o[6:0]}, 8'hC6);
    u_mst.put(8'hC0, a);
    chk(8'({u_dut.ram_wr_o[13:8], a}), 8'h47);
    chk(u_dut.ram_wr_o[7:0], 8'h3F);
    u_mst.pulse(1'b0);
    u_mst.pulse(1'b1);
    u_mst.put(8'h43, a);
    u_mst.put(8'hA0, a);
    chk(8'({u_dut.ram_wr_o[13:8], a}), 8'h49);
    chk({u_dut.blink_alt_o, u_dut.ram_wr_o[6:0]}, 8'h75);
    u_mst.pulse(1'b0);
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    t_mux4;
    t_static;
    t_mux23;
    tally_and_finish;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 400) begin
      miscompares++;
      tally_and_finish;
    end
  end
endmodule
